//--- dma_pins_pkg.sv
// Purpose: shared constants for the dma request and modem output block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   byte address of a register is four times its index
package dma_pins_pkg;

  // ==========================================================================
  // register indices and byte addresses
  localparam logic [2:0] IDX_DATA   = 3'h0;
  localparam logic [2:0] IDX_FIFO   = 3'h2;
  localparam logic [2:0] IDX_MODEM  = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam logic [7:0] ADDR_DATA   = {3'h0, IDX_DATA, 2'h0};
  localparam logic [7:0] ADDR_FIFO   = {3'h0, IDX_FIFO, 2'h0};
  localparam logic [7:0] ADDR_MODEM  = {3'h0, IDX_MODEM, 2'h0};
  localparam logic [7:0] ADDR_STATUS = {3'h0, IDX_STATUS, 2'h0};

  // ==========================================================================
  // fifo_control_reg fields
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXCLR_BIT = 1;
  localparam int FCR_TXCLR_BIT = 2;
  localparam int FCR_DMA_BIT   = 3;
  localparam int FCR_TRIG_LSB  = 6;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [7:0] FCR_KEEP  = 8'hc9;

  // ==========================================================================
  // modem_control_reg fields
  localparam int MCR_RTS_BIT  = 1;
  localparam int MCR_LOOP_BIT = 4;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] MCR_KEEP  = 8'h1f;

  // ==========================================================================
  // status register fields
  localparam int ST_RXCNT_LSB = 0;
  localparam int ST_TXCNT_LSB = 8;
  localparam int ST_RXREQ_BIT = 16;
  localparam int ST_TXREQ_BIT = 17;
  localparam int ST_RTS_BIT   = 18;

  // ==========================================================================
  // fifo sizes and receive trigger levels
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] HOLD_DEPTH = 5'h01;
  localparam logic [4:0] TRIG_LVL0  = 5'h01;
  localparam logic [4:0] TRIG_LVL1  = 5'h04;
  localparam logic [4:0] TRIG_LVL2  = 5'h08;
  localparam logic [4:0] TRIG_LVL3  = 5'h0e;

  // master reset pin synchroniser length
  localparam int MRST_SYNC_LEN = 3;

endpackage

//--- tx_skid_buffer.sv
// Purpose: two-entry valid/ready buffer between transmit fifo and transmitter
// Assumes: single clock, same domain on both sides
// Notes:   in_ready and out_valid come straight from flip-flops
`timescale 1ns/1ps
module tx_skid_buffer (
  input  wire logic       pclk,      // block clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       flush,     // drop both entries
  input  wire logic       in_valid,  // word offered
  input  wire logic [7:0] in_data,   // offered word
  output logic            in_ready,  // room for a word
  output logic            out_valid, // head word present
  output logic [7:0]      out_data,  // head word
  input  wire logic       out_ready  // consumer takes head
);

  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic       v0;
    logic       v1;
  } skid_state_type;

  skid_state_type s_q;
  skid_state_type s_d;

  // ==========================================================================
  // next state: pop shifts slot1 forward, push fills first free slot
  always_comb begin
    s_d = s_q;
    if (s_q.v0 && out_ready) begin
      s_d.d0 = s_q.d1;
      s_d.v0 = s_q.v1;
      s_d.v1 = 1'b0;
    end
    if (in_valid && !s_q.v1) begin
      if (!s_d.v0) begin
        s_d.d0 = in_data;
        s_d.v0 = 1'b1;
      end else begin
        s_d.d1 = in_data;
        s_d.v1 = 1'b1;
      end
    end
    if (flush) begin
      s_d.v0 = 1'b0;
      s_d.v1 = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = !s_q.v1;
  assign out_valid = s_q.v0;
  assign out_data  = s_q.d0;

endmodule

//--- dma_pins_top.sv
// Purpose: dma request, request-to-send and serial idle outputs of a fifo uart
// Assumes: apb slave on pclk; receiver and transmitter logic share pclk
// Notes:   master_reset is an asynchronous pin, synchronised before use
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dma_pins_top
  import dma_pins_pkg::*;
(
  input  wire logic        pclk,             // 250 mhz block clock
  input  wire logic        presetn,          // async reset, active low
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb write
  input  wire logic [31:0] pwdata,           // apb write data
  input  wire logic [3:0]  pstrb,            // apb byte strobes
  output logic [31:0]      prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped address or status write
  input  wire logic        master_reset,     // master reset pin, active high
  input  wire logic        rx_char_valid,    // receiver offers a character
  input  wire logic [7:0]  rx_char_data,     // received character
  output logic             rx_char_ready,    // receive fifo takes a character
  input  wire logic        rx_timeout,       // receive time-out pulse
  output logic             tx_char_valid,    // character for transmitter
  output logic [7:0]       tx_char_data,     // character for transmitter
  input  wire logic        tx_char_ready,    // transmitter takes character
  input  wire logic        tx_line_level,    // serialiser line level
  output logic             serial_tx,        // serial transmit output
  output logic             rts_n,            // request to send, active low
  output logic             rx_dma_request_n, // receive dma request, active low
  output logic             tx_dma_request_n  // transmit dma request, active low
);

  typedef struct packed {
    logic [MRST_SYNC_LEN-1:0] mrst_sync;
    logic                     mrst_q;
    logic [7:0]               fifo_control_reg;
    logic [7:0]               modem_control_reg;
    logic [15:0][7:0]         rx_mem;
    logic [3:0]               rx_wr;
    logic [3:0]               rx_rd;
    logic [4:0]               rx_cnt;
    logic [15:0][7:0]         tx_mem;
    logic [3:0]               tx_wr;
    logic [3:0]               tx_rd;
    logic [4:0]               tx_cnt;
    logic                     rx_latch;
    logic                     rx_req_n;
    logic                     tx_req_n;
    logic                     rts_n;
    logic                     txd;
    logic                     rx_ready;
    logic                     flush_tx;
    logic                     pready;
    logic                     pslverr;
    logic                     pop_pend;
    logic [31:0]              prdata;
  } state_type;

  // reset image: outputs at their inactive levels, fifos empty
  function automatic state_type reset_image();
    state_type r;
    r          = '0;
    r.fifo_control_reg      = FCR_RESET;
    r.modem_control_reg      = MCR_RESET;
    r.rx_req_n = 1'b1;
    r.tx_req_n = 1'b1;
    r.rts_n    = 1'b1;
    r.txd      = 1'b1;
    return r;
  endfunction

  state_type s_q;
  state_type s_d;

  logic buf_in_ready;

  // ==========================================================================
  // transmit buffer: a stall by the transmitter backs up into the tx fifo
  tx_skid_buffer u_tx_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (s_q.flush_tx),
    .in_valid  (s_q.tx_cnt != 5'h00),
    .in_data   (s_q.tx_mem[s_q.tx_rd]),
    .in_ready  (buf_in_ready),
    .out_valid (tx_char_valid),
    .out_data  (tx_char_data),
    .out_ready (tx_char_ready)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic       prep;
    logic       access;
    logic       fifo_on;
    logic       mode1;
    logic [4:0] cap;
    logic [4:0] trig;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_flush;
    logic       tx_flush;
    logic [7:0] new_fcr;
    prep     = 1'b0;
    access   = 1'b0;
    fifo_on  = 1'b0;
    mode1    = 1'b0;
    cap      = HOLD_DEPTH;
    trig     = TRIG_LVL0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_flush = 1'b0;
    tx_flush = 1'b0;
    new_fcr  = s_q.fifo_control_reg;
    s_d      = s_q;

    // master reset pin: first stage read only by the second
    // a pulse shorter than two edges is ignored; hold the pin four edges
    s_d.mrst_sync = {s_q.mrst_sync[MRST_SYNC_LEN-2:0], master_reset};
    if (s_q.mrst_sync[2] == s_q.mrst_sync[1]) begin
      s_d.mrst_q = s_q.mrst_sync[2];
    end

    // apb: prep cycle loads answer, ready edge commits the access
    prep   = psel && penable && !s_q.pready;
    access = psel && penable && s_q.pready;
    s_d.pready   = prep;
    s_d.flush_tx = 1'b0;
    if (prep) begin
      s_d.prdata   = '0;
      s_d.pslverr  = 1'b0;
      s_d.pop_pend = 1'b0;
      if (paddr == ADDR_DATA) begin
        if (!pwrite) begin
          s_d.prdata[7:0] = s_q.rx_mem[s_q.rx_rd];
          // the pop is only noted here; it lands at the ready edge
          s_d.pop_pend    = s_q.rx_cnt != 5'h00;
        end
      end else if (paddr == ADDR_FIFO) begin
        s_d.prdata[7:0] = s_q.fifo_control_reg;
      end else if (paddr == ADDR_MODEM) begin
        s_d.prdata[7:0] = s_q.modem_control_reg;
      end else if (paddr == ADDR_STATUS) begin
        s_d.prdata[ST_RXCNT_LSB +: 5] = s_q.rx_cnt;
        s_d.prdata[ST_TXCNT_LSB +: 5] = s_q.tx_cnt;
        s_d.prdata[ST_RXREQ_BIT]      = s_q.rx_req_n;
        s_d.prdata[ST_TXREQ_BIT]      = s_q.tx_req_n;
        s_d.prdata[ST_RTS_BIT]        = s_q.rts_n;
        // status is read-only, so a write there is answered with an error
        s_d.pslverr                   = pwrite;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    // transmit fifo room is judged by the mode that stood before this edge
    fifo_on = s_q.fifo_control_reg[FCR_EN_BIT];
    cap     = fifo_on ? FIFO_DEPTH : HOLD_DEPTH;

    // register writes take effect only at the ready edge
    if (access && pwrite && pstrb[0]) begin
      if (paddr == ADDR_FIFO) begin
        // toggling fifo_enable empties both fifos; the tx buffer flushes one edge later, so its head character can still go out
        new_fcr  = pwdata[7:0] & FCR_KEEP;
        rx_flush = pwdata[FCR_RXCLR_BIT] || (new_fcr[FCR_EN_BIT] != fifo_on);
        tx_flush = pwdata[FCR_TXCLR_BIT] || (new_fcr[FCR_EN_BIT] != fifo_on);
        s_d.fifo_control_reg  = new_fcr;
      end else if (paddr == ADDR_MODEM) begin
        s_d.modem_control_reg = pwdata[7:0] & MCR_KEEP;
      end else if (paddr == ADDR_DATA) begin
        // a word written to a full fifo is dropped; software watches the request
        tx_push = s_q.tx_cnt < cap;
      end
    end
    rx_pop  = access && s_q.pop_pend;
    rx_push = rx_char_valid && s_q.rx_ready;
    // the fifo feeds the buffer whenever a slot is free
    tx_pop  = (s_q.tx_cnt != 5'h00) && buf_in_ready;

    // receive fifo
    if (rx_push) begin
      s_d.rx_mem[s_q.rx_wr] = rx_char_data;
      s_d.rx_wr             = s_q.rx_wr + 4'h1;
    end
    if (rx_pop) begin
      s_d.rx_rd = s_q.rx_rd + 4'h1;
    end
    s_d.rx_cnt = s_q.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    if (rx_flush) begin
      s_d.rx_wr  = 4'h0;
      s_d.rx_rd  = 4'h0;
      s_d.rx_cnt = 5'h00;
    end
    // ready is the registered image of room after this cycle
    s_d.rx_ready = s_d.rx_cnt < (new_fcr[FCR_EN_BIT] ? FIFO_DEPTH : HOLD_DEPTH);

    // transmit fifo
    if (tx_push) begin
      s_d.tx_mem[s_q.tx_wr] = pwdata[7:0];
      s_d.tx_wr             = s_q.tx_wr + 4'h1;
    end
    if (tx_pop) begin
      s_d.tx_rd = s_q.tx_rd + 4'h1;
    end
    s_d.tx_cnt = s_q.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    if (tx_flush) begin
      s_d.tx_wr    = 4'h0;
      s_d.tx_rd    = 4'h0;
      s_d.tx_cnt   = 5'h00;
      s_d.flush_tx = 1'b1;
    end

    // mode and trigger follow the control value that stands after this edge,
    // so a request never lags a fifo_control_reg write by a cycle
    mode1 = new_fcr[FCR_EN_BIT] && new_fcr[FCR_DMA_BIT];
    case (new_fcr[FCR_TRIG_LSB +: 2])
      2'h0: trig = TRIG_LVL0;
      2'h1: trig = TRIG_LVL1;
      2'h2: trig = TRIG_LVL2;
      default: trig = TRIG_LVL3;
    endcase

    // receive request: mode 1 latches at trigger or time-out until empty
    if (s_d.rx_cnt == 5'h00) begin
      s_d.rx_latch = 1'b0;
    end else if ((s_d.rx_cnt >= trig) || rx_timeout) begin
      s_d.rx_latch = 1'b1;
    end
    if (mode1) begin
      s_d.rx_req_n = !s_d.rx_latch;
    end else begin
      s_d.rx_req_n = s_d.rx_cnt == 5'h00;
    end

    // transmit request
    // only the fifo is counted; the two buffer slots are invisible here
    if (mode1) begin
      s_d.tx_req_n = s_d.tx_cnt >= FIFO_DEPTH;
    end else begin
      s_d.tx_req_n = s_d.tx_cnt != 5'h00;
    end

    // rts is an output; only the status register read (ST_RTS_BIT) reads it back
    s_d.rts_n = !(s_d.modem_control_reg[MCR_RTS_BIT] && !s_d.modem_control_reg[MCR_LOOP_BIT]);
    // loopback keeps the line at mark so the far end sees idle
    s_d.txd   = s_d.modem_control_reg[MCR_LOOP_BIT] ? 1'b1 : tx_line_level;

    // synchronised master reset overrides all but the synchroniser and the apb answer registers; a read answers zero with no error
    if (s_q.mrst_q) begin
      s_d           = reset_image();
      s_d.mrst_sync = {s_q.mrst_sync[MRST_SYNC_LEN-2:0], master_reset};
      s_d.mrst_q    = s_q.mrst_sync[2] == s_q.mrst_sync[1] ?
                      s_q.mrst_sync[2] : s_q.mrst_q;
      s_d.flush_tx  = 1'b1;
      s_d.pready    = prep;
      s_d.prdata    = prep ? 32'h0000_0000 : s_q.prdata;
      s_d.pslverr   = 1'b0;
    end
  end

  // ==========================================================================
  // state register
  // both resets load reset_image, so the rts, serial and dma request outputs match whichever came last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= reset_image();
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign rx_char_ready    = s_q.rx_ready;
  assign serial_tx        = s_q.txd;
  assign rts_n            = s_q.rts_n;
  assign rx_dma_request_n = s_q.rx_req_n;
  assign tx_dma_request_n = s_q.tx_req_n;

endmodule

//--- dma_pins_monitor.sv
// Purpose: port checks on dma requests, rts_n and serial_tx
// Assumes: bound into dma_pins_top, one pclk domain
// Notes:   master_reset is synchronised, so its recent history excuses changes
`timescale 1ns/1ps
module dma_pins_monitor (
  input wire logic       pclk,          // clock
  input wire logic       presetn,       // reset
  input wire logic       psel,          // apb
  input wire logic       penable,       // apb
  input wire logic       pwrite,        // apb
  input wire logic       pready,        // apb
  input wire logic       master_reset,  // pin
  input wire logic       rx_char_valid, // rx stream
  input wire logic       rx_char_ready, // rx stream
  input wire logic       rx_timeout,    // time-out
  input wire logic       tx_char_valid, // tx stream
  input wire logic [7:0] tx_char_data,  // tx stream
  input wire logic       tx_char_ready, // tx stream
  input wire logic       tx_line_level, // serialiser
  input wire logic       serial_tx,     // line
  input wire logic       rts_n,         // rts
  input wire logic       rx_dma_request_n, // rx request
  input wire logic       tx_dma_request_n  // tx request
);
  // ==========================================================================
  // master reset history
  logic [7:0] mr_q;
  logic       mr_any;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mr_q <= 8'h00;
    else
      mr_q <= {mr_q[6:0], master_reset};
  end
  assign mr_any = master_reset | (|mr_q);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence acc_s;
    !pready ##1 pready;
  endsequence
  sequence mr_s;
    master_reset [*6];
  endsequence
  apb_wait_a: assert property ($rose(psel && penable) |-> acc_s)
    else $error("apb access not one wait state");
  mr_quiet_a: assert property (mr_s |->
    rts_n && serial_tx && rx_dma_request_n && tx_dma_request_n)
    else $error("outputs not at reset levels");
  rts_link_a: assert property (!rts_n |-> serial_tx == $past(tx_line_level))
    else $error("serial_tx not following line");
  rx_fall_a: assert property ($fell(rx_dma_request_n) |->
    $past(rx_char_valid && rx_char_ready || rx_timeout || pready && pwrite))
    else $error("rx request asserted without cause");
  rx_rise_a: assert property ($rose(rx_dma_request_n) |-> $past(pready) || mr_any)
    else $error("rx request released without access");
  tx_rise_a: assert property ($rose(tx_dma_request_n) |->
    $past(pready && pwrite) || mr_any)
    else $error("tx request released without write");
  rts_chg_a: assert property ($changed(rts_n) |-> $past(pready && pwrite) || mr_any)
    else $error("rts_n changed without write");
  tx_hold_a: assert property (tx_char_valid && !tx_char_ready |=>
    tx_char_valid && $stable(tx_char_data) || mr_any)
    else $error("stalled tx word lost");
endmodule

bind dma_pins_top dma_pins_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .master_reset, .rx_char_valid, .rx_char_ready, .rx_timeout, .tx_char_valid,
  .tx_char_data, .tx_char_ready, .tx_line_level, .serial_tx, .rts_n,
  .rx_dma_request_n, .tx_dma_request_n);

//--- far_side_model.sv
// Purpose: receiver and transmitter standing beside the block
// Assumes: same clock as the block
// Notes:   idle data lines show the inverse of the last character
`timescale 1ns/1ps
module far_side_model (
  input  wire logic  pclk,          // clock
  input  wire logic  presetn,       // reset
  input  wire logic  take,          // transmitter may accept
  input  wire logic  rx_char_ready, // receive fifo room
  output logic       rx_char_valid, // character offered
  output logic [7:0] rx_char_data,  // offered character
  output logic       tx_char_ready, // transmitter accepts
  output logic       tx_line_level  // serialiser level
);
  logic [7:0] nxt = 8'h40;
  initial begin
    rx_char_valid = 1'h0;
    rx_char_data = 8'h00;
    tx_line_level = 1'h1;
  end
  assign tx_char_ready = take;
  // a moving line makes a stuck serial_tx visible
  always @(posedge pclk)
    tx_line_level <= presetn ? ~tx_line_level : 1'h1;
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      rx_char_valid <= 1'h1;
      rx_char_data <= nxt;
      nxt = nxt + 8'h01;
      do @(posedge pclk); while (rx_char_ready !== 1'h1);
    end
    rx_char_valid <= 1'h0;
    rx_char_data <= ~rx_char_data;
    @(posedge pclk);
  endtask
endmodule

//--- test_uart_dma_ready_and_rts_outputs.sv
// Purpose: self-checking bench for dma_pins_top
// Assumes: apb master, stalling transmitter from far_side_model
// Notes:   read data and tx words are noted in queues and compared when seen
`timescale 1ns/1ps
module test_uart_dma_ready_and_rts_outputs;
  import dma_pins_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        master_reset = 1'h0;
  logic        rx_timeout = 1'h0;
  logic        take = 1'h0;
  logic        hold = 1'h1;
  logic [31:0] prdata;
  logic [7:0]  rx_char_data, tx_char_data;
  logic        pready, pslverr, rx_char_valid, rx_char_ready, tx_char_valid, tx_char_ready;
  logic        tx_line_level, serial_tx, rts_n, rx_dma_request_n, tx_dma_request_n;
  logic [31:0] rng = 32'h1f;
  logic [32:0] e;
  logic [32:0] aq[$];
  logic [7:0]  tq[$];
  logic [7:0]  rxe = 8'h40;
  logic [4:0]  lv[4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
  int          failures, n_checks, cyc;
  dma_pins_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .master_reset, .rx_char_valid, .rx_char_data,
    .rx_char_ready, .rx_timeout, .tx_char_valid, .tx_char_data, .tx_char_ready,
    .tx_line_level, .serial_tx, .rts_n, .rx_dma_request_n, .tx_dma_request_n);
  far_side_model far (.pclk, .presetn, .take, .rx_char_ready, .rx_char_valid,
    .rx_char_data, .tx_char_ready, .tx_line_level);
  always #2 pclk = ~pclk;
  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task finish_test();
    $display("failures %0d n_checks %0d", failures, n_checks);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task pins(input logic r, input logic t);
    cmp("rx_dma_request_n", {31'h0, r}, {31'h0, rx_dma_request_n});
    cmp("tx_dma_request_n", {31'h0, t}, {31'h0, tx_dma_request_n});
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    aq.push_back(x);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, {1'h0, x});
  endtask
  task rdc();
    rd(ADDR_DATA, {24'h0, rxe});
    rxe = rxe + 8'h01;
  endtask
  task ptx(input logic [7:0] d, input logic k);
    wr(ADDR_DATA, {24'h0, d});
    if (k)
      tq.push_back(d);
  endtask
  // ==========================================================================
  // watchers, random stall and time limit
  always @(posedge pclk) begin
    rng <= xs(rng);
    take <= ~hold & rng[0];
    cyc <= cyc + 1;
    if (psel && pready === 1'h1) begin
      e = aq.pop_front();
      cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (!pwrite)
        cmp("prdata", e[31:0], prdata);
    end
    if (tx_char_valid === 1'h1 && tx_char_ready === 1'h1)
      cmp("tx_char_data", {24'h0, tq.pop_front()}, {24'h0, tx_char_data});
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(ADDR_FIFO, 32'h0);
    rd(ADDR_MODEM, 32'h0);
    rd(ADDR_STATUS, 32'h0005_0000);
    apb(1'h0, 8'h04, 32'h0, {1'h1, 32'h0});
    pins(1'h1, 1'h0);
    wr(ADDR_FIFO, 32'h08);
    far.send(1);
    pins(1'h0, 1'h0);
    rdc();
    pins(1'h1, 1'h0);
    wr(ADDR_FIFO, 32'h01);
    far.send(3);
    pins(1'h0, 1'h0);
    repeat (2) rdc();
    pins(1'h0, 1'h0);
    rdc();
    pins(1'h1, 1'h0);
    rd(ADDR_DATA, 32'h0);
    wr(ADDR_MODEM, 32'h02);
    cmp("rts_n", 32'h0, {31'h0, rts_n});
    for (int i = 0; i < 3; i++) ptx(8'h80 + 8'(i), 1'h1);
    repeat (4) @(posedge pclk);
    pins(1'h1, 1'h1);
    hold <= 1'h0;
    repeat (40) @(posedge pclk);
    pins(1'h1, 1'h0);
    hold <= 1'h1;
    wr(ADDR_FIFO, 32'hc9);
    rd(ADDR_FIFO, 32'hc9);
    for (int i = 0; i < 17; i++) ptx(8'(i), 1'h1);
    pins(1'h1, 1'h0);
    ptx(8'h55, 1'h1);
    pins(1'h1, 1'h1);
    ptx(8'haa, 1'h0);
    hold <= 1'h0;
    repeat (80) @(posedge pclk);
    pins(1'h1, 1'h0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_FIFO, {24'h0, 2'(s), 6'h09});
      far.send(int'(lv[s]) - 1);
      pins(1'h1, 1'h0);
      far.send(1);
      pins(1'h0, 1'h0);
      repeat (int'(lv[s]) - 1) rdc();
      pins(1'h0, 1'h0);
      rdc();
      pins(1'h1, 1'h0);
    end
    far.send(2);
    rx_timeout <= 1'h1;
    @(posedge pclk);
    rx_timeout <= 1'h0;
    @(posedge pclk);
    pins(1'h0, 1'h0);
    repeat (2) rdc();
    pins(1'h1, 1'h0);
    far.send(1);
    wr(ADDR_FIFO, 32'hcb);
    rxe = rxe + 8'h01;
    rd(ADDR_STATUS, 32'h0001_0000);
    pstrb <= 4'he;
    wr(ADDR_MODEM, 32'h00);
    pstrb <= 4'hf;
    cmp("rts_n", 32'h0, {31'h0, rts_n});
    wr(ADDR_MODEM, 32'h12);
    cmp("rts_n", 32'h1, {31'h0, rts_n});
    apb(1'h1, ADDR_STATUS, 32'h0, {1'h1, 32'h0});
    wr(ADDR_MODEM, 32'h02);
    cmp("rts_n", 32'h0, {31'h0, rts_n});
    master_reset <= 1'h1;
    repeat (6) @(posedge pclk);
    cmp("rts_n", 32'h1, {31'h0, rts_n});
    cmp("serial_tx", 32'h1, {31'h0, serial_tx});
    pins(1'h1, 1'h1);
    master_reset <= 1'h0;
    @(posedge pclk);
    cmp("serial_tx", 32'h1, {31'h0, serial_tx});
    repeat (5) @(posedge pclk);
    rd(ADDR_MODEM, 32'h0);
    cmp("left", 32'h0, aq.size() + tq.size());
    finish_test();
  end
endmodule
